// ===== result_bank.sv
// Purpose: measurement result register bank with converter enable control
// Assumes: register port is a one-cycle read/write strobe from the serial slave
// Notes: over-voltage input is asynchronous and is synchronised
//
// Summary of operation
// - input current low register holds result bits 7:0, 1mA per count
// - charge current high register bits 3:0 hold result 11:8, rest zero
// - charge current low register holds result bits 7:0, 1mA per count
// - input voltage high register bits 4:0 hold result 12:8, rest zero
// - input voltage low register holds result bits 7:0, 1mV per count
// - input over-voltage clears converter enable, halting conversions
// - battery voltage high register bits 5:0 hold result 13:8, rest zero
// - battery voltage low register holds result bits 7:0, 1mV per count
// - system voltage high register bits 5:0 hold result 13:8, rest zero
// - system voltage low register holds result bits 7:0, 1mV per count
// - thermistor high register bits 1:0 hold ratio bits 9:8, rest zero
// - all result registers read zero after reset and register reset
// - input current high holds bits 11:8 and direction flag in bit 7
// - software sets converter enable; no conversions while it is zero
// - register reset bit restores defaults then clears itself
`timescale 1ns/1ps
module result_bank
  import result_bank_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic input_over_voltage,
  input wire logic sample_valid,
  input wire sample_t sample_in,
  output logic converter_enable,
  output logic safety_timer_reset
);

  reg_access_t acc;
  sample_t held;
  logic ovp_meta;
  logic ovp_sync;
  logic [7:0] control;
  logic [7:0] next_control;
  logic reg_reset_pending;
  logic next_reg_reset_pending;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic next_timer_reset;
  logic wipe;

  assign acc = '{write: reg_write, read: reg_read, addr: reg_addr, wdata: reg_wdata};
  assign wipe = reg_reset_pending;

  function automatic logic [7:0] high_byte(input logic [15:0] v, input int w);
    logic [7:0] r;
    r = '0;
    for (int i = 8; i < 16; i++) begin
      if (i < w) begin
        r[i - 8] = v[i];
      end
    end
    return r;
  endfunction : high_byte

  sample_capture u_capture (
    .clk(clk),
    .srst(srst),
    .clear(wipe),
    .take(sample_valid && control[CONVERTER_ENABLE_BIT] && !ovp_sync),
    .sample_in(sample_in),
    .sample_out(held)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      ovp_meta <= 1'b0;
      ovp_sync <= 1'b0;
    end else begin
      ovp_meta <= input_over_voltage;
      ovp_sync <= ovp_meta;
    end
  end

  always_comb begin
    next_control = control;
    next_reg_reset_pending = 1'b0;
    next_timer_reset = 1'b0;
    if (reg_reset_pending) begin
      next_control = CONTROL_RESET;
      next_timer_reset = 1'b1;
    end else begin
      if (acc.write && acc.addr == OFF_CONVERTER_CONTROL) begin
        next_control = control & ~CONTROL_WRITE_MASK;
        next_control = next_control | (acc.wdata & CONTROL_WRITE_MASK);
      end
      if (acc.write && acc.addr == OFF_PART_INFO && acc.wdata[REGISTER_RESET_BIT]) begin
        next_reg_reset_pending = 1'b1;
      end
    end
    if (ovp_sync) begin
      next_control[CONVERTER_ENABLE_BIT] = 1'b0;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    next_rvalid = acc.read;
    unique case (acc.addr)
      OFF_INPUT_CURRENT_HIGH: begin
        next_rdata = high_byte({4'h0, held.input_current_result}, CURRENT_WIDTH);
        next_rdata[DIRECTION_BIT] = held.input_current_direction;
      end
      OFF_INPUT_CURRENT_LOW: next_rdata = held.input_current_result[7:0];
      OFF_CHARGE_CURRENT_HIGH: begin
        next_rdata = high_byte({4'h0, held.charge_current_result}, CURRENT_WIDTH);
      end
      OFF_CHARGE_CURRENT_LOW: next_rdata = held.charge_current_result[7:0];
      OFF_INPUT_VOLTAGE_HIGH: begin
        next_rdata = high_byte({3'h0, held.input_voltage_result}, INPUT_VOLTAGE_WIDTH);
      end
      OFF_INPUT_VOLTAGE_LOW: next_rdata = held.input_voltage_result[7:0];
      OFF_BATTERY_VOLTAGE_HIGH: begin
        next_rdata = high_byte({2'h0, held.battery_voltage_result}, RAIL_VOLTAGE_WIDTH);
      end
      OFF_BATTERY_VOLTAGE_LOW: next_rdata = held.battery_voltage_result[7:0];
      OFF_SYSTEM_VOLTAGE_HIGH: begin
        next_rdata = high_byte({2'h0, held.system_voltage_result}, RAIL_VOLTAGE_WIDTH);
      end
      OFF_SYSTEM_VOLTAGE_LOW: next_rdata = held.system_voltage_result[7:0];
      OFF_THERMISTOR_RATIO_HIGH: begin
        next_rdata = high_byte({6'h00, held.thermistor_ratio_result}, RATIO_WIDTH);
      end
      OFF_CONVERTER_CONTROL: next_rdata = control;
      OFF_PART_INFO: next_rdata = {reg_reset_pending, 7'h00};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      control <= CONTROL_RESET;
      reg_reset_pending <= 1'b0;
      reg_rdata <= RESULT_RESET;
      reg_rvalid <= 1'b0;
      converter_enable <= 1'b0;
      safety_timer_reset <= 1'b0;
    end else begin
      control <= next_control;
      reg_reset_pending <= next_reg_reset_pending;
      reg_rdata <= next_rdata;
      reg_rvalid <= next_rvalid;
      converter_enable <= next_control[CONVERTER_ENABLE_BIT];
      safety_timer_reset <= next_timer_reset;
    end
  end

endmodule : result_bank

// ===== result_bank_bench.sv
// Purpose: self-checking bench for the result register bank
// Assumes: inputs driven at falling edge, fixed seed
// Notes: expected bytes come from the bench's own field split
`timescale 1ns/1ps
module result_bank_bench
  import result_bank_pkg::*;
;
  logic clk = 0, srst = 1, reg_write = 0, reg_read = 0, input_over_voltage = 0;
  logic sample_valid = 0, reg_rvalid, converter_enable, safety_timer_reset;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  sample_t sample_in = '0, s, p;
  int error_cnt = 0, n_compared = 0;
  always #25 clk = ~clk;
  result_bank uut (.clk, .srst, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .input_over_voltage, .sample_valid, .sample_in, .converter_enable,
    .safety_timer_reset);
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_read = 1;
    reg_addr = a;
    @(negedge clk);
    reg_read = 0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_write = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_write = 0;
  endtask : wr
  task push(input sample_t v);
    @(negedge clk);
    sample_in = v;
    sample_valid = 1;
    @(negedge clk);
    sample_valid = 0;
  endtask : push
  function automatic logic [7:0] expv(input sample_t v, input int i);
    case (i)
      0: return {v.input_current_direction, 3'h0, v.input_current_result[11:8]};
      1: return v.input_current_result[7:0];
      2: return {4'h0, v.charge_current_result[11:8]};
      3: return v.charge_current_result[7:0];
      4: return {3'h0, v.input_voltage_result[12:8]};
      5: return v.input_voltage_result[7:0];
      6: return {2'h0, v.battery_voltage_result[13:8]};
      7: return v.battery_voltage_result[7:0];
      8: return {2'h0, v.system_voltage_result[13:8]};
      9: return v.system_voltage_result[7:0];
      10: return {6'h00, v.thermistor_ratio_result[9:8]};
      default: return 8'h00;
    endcase
  endfunction : expv
  task check_all(input sample_t v);
    for (int i = 0; i < 12; i += 2) begin
      rd(OFF_INPUT_CURRENT_HIGH + 8'(i));
      chk(d, expv(v, i));
    end
    for (int i = 1; i < 12; i += 2) begin
      rd(OFF_INPUT_CURRENT_HIGH + 8'(i));
      chk(d, expv(v, i));
    end
  endtask : check_all
  task rnd;
    logic [95:0] r;
    r = {$urandom(), $urandom(), $urandom()};
    s = r[$bits(sample_t)-1:0];
  endtask : rnd
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'h47d4));
    repeat (6) @(negedge clk);
    srst = 0;
    check_all('0);
    rd(OFF_CONVERTER_CONTROL);
    chk(d, CONTROL_RESET);
    rnd;
    push(s);
    check_all('0);
    wr(OFF_CONVERTER_CONTROL, 8'hcf);
    chk({7'h0, converter_enable}, 8'h01);
    rd(OFF_CONVERTER_CONTROL);
    chk(d, 8'hc0);
    s = '1;
    repeat (5) begin
      push(s);
      check_all(s);
      p = s;
      rnd;
    end
    input_over_voltage = 1;
    repeat (4) @(negedge clk);
    chk({7'h0, converter_enable}, 8'h00);
    rd(OFF_CONVERTER_CONTROL);
    chk(d, 8'h40);
    push(s);
    check_all(p);
    input_over_voltage = 0;
    repeat (3) @(negedge clk);
    wr(OFF_CONVERTER_CONTROL, 8'h80);
    chk({7'h0, converter_enable}, 8'h01);
    wr(OFF_PART_INFO, 8'h80);
    repeat (1) @(negedge clk);
    chk({6'h0, safety_timer_reset, converter_enable}, 8'h02);
    check_all('0);
    rd(OFF_CONVERTER_CONTROL);
    chk(d, CONTROL_RESET);
    rd(OFF_PART_INFO);
    chk(d, 8'h00);
    finish_test;
  end
endmodule : result_bank_bench
bind result_bank result_bank_properties chk (.clk, .srst, .reg_write, .reg_read, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rvalid, .input_over_voltage, .converter_enable,
  .safety_timer_reset);

// ===== result_bank_pkg.sv
// Purpose: constants and carrier types for the measurement result register bank
// Assumes: 8-bit register port with 8-bit addresses
// Notes: offsets are register addresses on the serial register port
package result_bank_pkg;

  localparam logic [7:0] OFF_INPUT_CURRENT_HIGH = 8'h17;
  localparam logic [7:0] OFF_CONVERTER_CONTROL = 8'h15;
  localparam logic [7:0] OFF_INPUT_CURRENT_LOW = 8'h18;
  localparam logic [7:0] OFF_CHARGE_CURRENT_HIGH = 8'h19;
  localparam logic [7:0] OFF_CHARGE_CURRENT_LOW = 8'h1a;
  localparam logic [7:0] OFF_INPUT_VOLTAGE_HIGH = 8'h1b;
  localparam logic [7:0] OFF_INPUT_VOLTAGE_LOW = 8'h1c;
  localparam logic [7:0] OFF_BATTERY_VOLTAGE_HIGH = 8'h1d;
  localparam logic [7:0] OFF_BATTERY_VOLTAGE_LOW = 8'h1e;
  localparam logic [7:0] OFF_SYSTEM_VOLTAGE_HIGH = 8'h1f;
  localparam logic [7:0] OFF_SYSTEM_VOLTAGE_LOW = 8'h20;
  localparam logic [7:0] OFF_THERMISTOR_RATIO_HIGH = 8'h21;
  localparam logic [7:0] OFF_PART_INFO = 8'h25;

  localparam int CONVERTER_ENABLE_BIT = 7;
  localparam int REGISTER_RESET_BIT = 7;
  localparam int DIRECTION_BIT = 7;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h30;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'hf0;

  localparam int CURRENT_WIDTH = 12;
  localparam int INPUT_VOLTAGE_WIDTH = 13;
  localparam int RAIL_VOLTAGE_WIDTH = 14;
  localparam int RATIO_WIDTH = 10;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic input_current_direction;
    logic [11:0] input_current_result;
    logic [11:0] charge_current_result;
    logic [12:0] input_voltage_result;
    logic [13:0] battery_voltage_result;
    logic [13:0] system_voltage_result;
    logic [9:0] thermistor_ratio_result;
  } sample_t;

endpackage : result_bank_pkg

// ===== result_bank_properties.sv
// Purpose: port-level properties of the result register bank
// Assumes: single clk domain, srst synchronous active high
// Notes: bound to result_bank from the bench top file
`timescale 1ns/1ps
module result_bank_properties
  import result_bank_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic input_over_voltage,
  input wire logic converter_enable,
  input wire logic safety_timer_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rst_req;
    !(reg_write && reg_addr == OFF_PART_INFO && reg_wdata[REGISTER_RESET_BIT])
      ##1 (reg_write && reg_addr == OFF_PART_INFO && reg_wdata[REGISTER_RESET_BIT]);
  endsequence
  sequence s_rst_pulse;
    ##2 safety_timer_reset ##1 !safety_timer_reset;
  endsequence
  property p_ch_hi; reg_read && reg_addr == OFF_CHARGE_CURRENT_HIGH
    |=> reg_rvalid && reg_rdata[7:4] == 4'h0; endproperty
  a_ch_hi: assert property (p_ch_hi) else $error("charge high reserved bits set");
  property p_iv_hi; reg_read && reg_addr == OFF_INPUT_VOLTAGE_HIGH
    |=> reg_rvalid && reg_rdata[7:5] == 3'h0; endproperty
  a_iv_hi: assert property (p_iv_hi) else $error("voltage high reserved bits set");
  property p_bat_hi; reg_read && reg_addr == OFF_BATTERY_VOLTAGE_HIGH
    |=> reg_rvalid && reg_rdata[7:6] == 2'h0; endproperty
  a_bat_hi: assert property (p_bat_hi) else $error("battery high reserved bits set");
  property p_ratio_hi; reg_read && reg_addr == OFF_THERMISTOR_RATIO_HIGH
    |=> reg_rvalid && reg_rdata[7:2] == 6'h00; endproperty
  a_ratio_hi: assert property (p_ratio_hi) else $error("ratio high reserved bits set");
  property p_ovp; input_over_voltage [*3] |=> !converter_enable; endproperty
  a_ovp: assert property (p_ovp) else $error("enable kept during over-voltage");
  property p_en_set; !input_over_voltage ##1 (!input_over_voltage && !(reg_write
    && reg_addr == OFF_PART_INFO && reg_wdata[REGISTER_RESET_BIT])) ##1 (!input_over_voltage
    && reg_write && reg_wdata[CONVERTER_ENABLE_BIT] && reg_addr == OFF_CONVERTER_CONTROL)
    |=> converter_enable; endproperty
  a_en_set: assert property (p_en_set) else $error("enable not set by write");
  property p_rst_pulse; s_rst_req |-> s_rst_pulse; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("timer reset pulse wrong");
  property p_rst_en; s_rst_req |-> ##2 !converter_enable; endproperty
  a_rst_en: assert property (p_rst_en) else $error("enable kept after reset");
endmodule : result_bank_properties

// ===== sample_capture.sv
// Purpose: holds one complete conversion sample, updated atomically
// Assumes: sample_valid is a one-cycle pulse on clk with all fields valid
// Notes: cleared by reset or register reset
`timescale 1ns/1ps
module sample_capture
  import result_bank_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic clear,
  input wire logic take,
  input wire sample_t sample_in,
  output sample_t sample_out
);

  sample_t held;
  sample_t next_held;

  always_comb begin
    next_held = held;
    if (clear) begin
      next_held = '0;
    end else if (take) begin
      next_held = sample_in;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  assign sample_out = held;

endmodule : sample_capture
